// ==== pkg/tcdac_pkg.sv ====
// constants for the two-channel converter control block
`default_nettype none
package tcdac_pkg;
  // register byte offsets (all multiples of four: index times four)
  localparam logic [19:0] IDX_STANDBY_CONTROL = 20'hEE01A;
  localparam logic [19:0] IDX_CHAN0_VALUE     = 20'hFFF9C;
  localparam logic [19:0] IDX_CHAN1_VALUE     = 20'hFFF9D;
  localparam logic [19:0] IDX_CONTROL         = 20'hFFF9E;
  localparam int          ADDR_W              = 22;
  localparam logic [ADDR_W-1:0] ADDR_STANDBY_CONTROL = {IDX_STANDBY_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CHAN0_VALUE     = {IDX_CHAN0_VALUE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CHAN1_VALUE     = {IDX_CHAN1_VALUE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CONTROL         = {IDX_CONTROL, 2'b00};
  // reset values
  localparam logic [7:0] RST_VALUE           = 8'h00;
  localparam logic [7:0] RST_CONTROL         = 8'h1F;
  localparam logic [7:0] RST_STANDBY_CONTROL = 8'hFE;
  // field positions
  localparam int BIT_CHAN1_OE    = 7;
  localparam int BIT_CHAN0_OE    = 6;
  localparam int BIT_JOINT       = 5;
  localparam int BIT_STANDBY_OE  = 0;
  // reserved bits read as one
  localparam logic [7:0] RSV_CONTROL         = 8'h1F;
  localparam logic [7:0] RSV_STANDBY_CONTROL = 8'hFE;
  localparam logic [31:0] UNMAPPED_READ      = 32'h0000_0000;
endpackage : tcdac_pkg
`default_nettype wire

// ==== hdl/tcdac_top.sv ====
// two-channel 8-bit converter control registers and enables
//
// Local design decision: the Avalon-MM slave port.
`default_nettype none
module tcdac_top
  import tcdac_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  input  wire logic [tcdac_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [31:0]                 avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [31:0]                 avs_readdata_o,
  output logic                             avs_waitrequest_o,
  input  wire logic                        hw_standby_i,
  input  wire logic                        sw_standby_i,
  output logic      [7:0]                  conv0_data_o,
  output logic      [7:0]                  conv1_data_o,
  output logic                             conv0_enable_o,
  output logic                             conv1_enable_o,
  output logic                             conv0_load_o,
  output logic                             conv1_load_o,
  output logic                             analog_out_pin0_oe_n_o,
  output logic                             analog_out_pin1_oe_n_o
);
  import tcdac_pkg::*;

  logic [7:0] chan0_value_reg;
  logic [7:0] chan1_value_reg;
  logic [2:0] converter_control_reg;
  logic       standby_control_reg;
  logic       hws_meta;
  logic       hws_sync;
  logic       sws_meta;
  logic       sws_sync;
  logic       ack;
  logic       wr_hit;
  logic       rd_hit;
  logic       chan1_output_enable;
  logic       chan0_output_enable;
  logic       joint_conversion_enable;
  logic       standby_output_enable;
  logic       next_conv0_en;
  logic       next_conv1_en;
  logic       init_hw;
  logic       init_regs;
  logic       out_allowed;
  logic       wr_c0;
  logic       wr_c1;
  logic       wr_ctl;
  logic       wr_stb;
  logic [31:0] next_rdata;

  // standby inputs synchronised
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hws_meta <= 1'b0;
      hws_sync <= 1'b0;
      sws_meta <= 1'b0;
      sws_sync <= 1'b0;
    end else begin
      hws_meta <= hw_standby_i;
      hws_sync <= hws_meta;
      sws_meta <= sw_standby_i;
      sws_sync <= sws_meta;
    end
  end

  assign chan1_output_enable     = converter_control_reg[2];
  assign chan0_output_enable     = converter_control_reg[1];
  assign joint_conversion_enable = converter_control_reg[0];
  assign standby_output_enable   = standby_control_reg;

  // which reinitialisation applies
  assign init_hw   = hws_sync;
  assign init_regs = hws_sync | (sws_sync & ~standby_output_enable);
  assign out_allowed = ~hws_sync & (~sws_sync | standby_output_enable);

  // bus: one wait cycle, then acceptance; read data staged a cycle early
  assign wr_hit = avs_write_i & ~avs_waitrequest_o;
  assign rd_hit = avs_read_i & avs_waitrequest_o & ~ack;
  assign wr_c0  = wr_hit & avs_byteenable_i[0]
                  & (avs_address_i == ADDR_CHAN0_VALUE);
  assign wr_c1  = wr_hit & avs_byteenable_i[0]
                  & (avs_address_i == ADDR_CHAN1_VALUE);
  assign wr_ctl = wr_hit & avs_byteenable_i[0]
                  & (avs_address_i == ADDR_CONTROL);
  assign wr_stb = wr_hit & avs_byteenable_i[0]
                  & (avs_address_i == ADDR_STANDBY_CONTROL);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= ~avs_waitrequest_o;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o
                             & ~ack);
    end
  end

  // read data mux
  always_comb begin
    next_rdata = UNMAPPED_READ;
    unique case (avs_address_i)
      ADDR_CHAN0_VALUE:     next_rdata[7:0] = chan0_value_reg;
      ADDR_CHAN1_VALUE:     next_rdata[7:0] = chan1_value_reg;
      ADDR_CONTROL:         next_rdata[7:0] = {converter_control_reg,
                                               RSV_CONTROL[4:0]};
      ADDR_STANDBY_CONTROL: next_rdata[7:0] = {RSV_STANDBY_CONTROL[7:1],
                                               standby_control_reg};
      default:              next_rdata = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= UNMAPPED_READ;
    end else if (rd_hit) begin
      avs_readdata_o <= next_rdata;
    end
  end

  // channel value registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chan0_value_reg <= RST_VALUE;
      chan1_value_reg <= RST_VALUE;
    end else if (init_regs) begin
      chan0_value_reg <= RST_VALUE;
      chan1_value_reg <= RST_VALUE;
    end else begin
      if (wr_c0) begin
        chan0_value_reg <= avs_writedata_i[7:0];
      end
      if (wr_c1) begin
        chan1_value_reg <= avs_writedata_i[7:0];
      end
    end
  end

  // control register, reserved bits not stored
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      converter_control_reg <= RST_CONTROL[7:5];
    end else if (init_regs) begin
      converter_control_reg <= RST_CONTROL[7:5];
    end else if (wr_ctl) begin
      converter_control_reg <= avs_writedata_i[BIT_CHAN1_OE:BIT_JOINT];
    end
  end

  // standby control register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      standby_control_reg <= RST_STANDBY_CONTROL[BIT_STANDBY_OE];
    end else if (init_hw) begin
      standby_control_reg <= RST_STANDBY_CONTROL[BIT_STANDBY_OE];
    end else if (wr_stb) begin
      standby_control_reg <= avs_writedata_i[BIT_STANDBY_OE];
    end
  end

  // conversion enable decode
  always_comb begin
    next_conv0_en = 1'b1;
    next_conv1_en = 1'b1;
    if (!chan0_output_enable && !chan1_output_enable) begin
      next_conv0_en = 1'b0;
      next_conv1_en = 1'b0;
    end else if (!joint_conversion_enable) begin
      next_conv0_en = chan0_output_enable;
      next_conv1_en = chan1_output_enable;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv0_enable_o <= 1'b0;
      conv1_enable_o <= 1'b0;
    end else begin
      conv0_enable_o <= next_conv0_en & out_allowed;
      conv1_enable_o <= next_conv1_en & out_allowed;
    end
  end

  // data presented to converters, load pulse on new data while that channel's conversion is enabled
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv0_data_o <= RST_VALUE;
      conv1_data_o <= RST_VALUE;
      conv0_load_o <= 1'b0;
      conv1_load_o <= 1'b0;
    end else begin
      conv0_data_o <= chan0_value_reg;
      conv1_data_o <= chan1_value_reg;
      conv0_load_o <= wr_c0 & ~init_regs & next_conv0_en;
      conv1_load_o <= wr_c1 & ~init_regs & next_conv1_en;
    end
  end

  // pin drive from own output enable, gated by out_allowed (standby)
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      analog_out_pin0_oe_n_o <= 1'b1;
      analog_out_pin1_oe_n_o <= 1'b1;
    end else begin
      analog_out_pin0_oe_n_o <= ~(chan0_output_enable & out_allowed);
      analog_out_pin1_oe_n_o <= ~(chan1_output_enable & out_allowed);
    end
  end
endmodule : tcdac_top
`default_nettype wire

// ==== tb/tcdac_sva.sv ====
// assertion checker for the converter control block
`default_nettype none
module tcdac_sva (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        hw_standby_i,
  input wire logic        conv0_enable_o,
  input wire logic        conv1_enable_o,
  input wire logic        conv0_load_o,
  input wire logic        analog_out_pin0_oe_n_o,
  input wire logic        analog_out_pin1_oe_n_o
);
  timeunit 1ns / 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("wait low twice");
  chk_wait_idle: assert property (avs_waitrequest_o && !avs_read_i
    && !avs_write_i |=> avs_waitrequest_o) else $error("wait dropped");
  chk_read_hold: assert property ($changed(avs_readdata_o)
    |-> !avs_waitrequest_o) else $error("readdata moved");
  chk_load_pulse: assert property (conv0_load_o |=> !conv0_load_o)
    else $error("load too long");
  chk_load_en: assert property (conv0_load_o |-> conv0_enable_o)
    else $error("load while off");
  chk_oe0_conv: assert property (!analog_out_pin0_oe_n_o
    |-> conv0_enable_o) else $error("pin0 without conv");
  chk_oe1_conv: assert property (!analog_out_pin1_oe_n_o
    |-> conv1_enable_o) else $error("pin1 without conv");
  chk_conv_off: assert property (analog_out_pin0_oe_n_o
    && analog_out_pin1_oe_n_o |-> !conv0_enable_o && !conv1_enable_o)
    else $error("conv on, no enable");
  chk_hw_pins: assert property (hw_standby_i [*5] |->
    analog_out_pin0_oe_n_o && analog_out_pin1_oe_n_o && !conv0_enable_o)
    else $error("output in hw standby");
  cov_write: cover property (avs_write_i && !avs_waitrequest_o);
  cov_load: cover property (conv0_load_o);
  cov_joint: cover property (conv1_enable_o && analog_out_pin1_oe_n_o);
endmodule : tcdac_sva
bind tcdac_top tcdac_sva u_sva (.*);
`default_nettype wire

// ==== tb/tcdac_analog.sv ====
// model of one analog output channel
`default_nettype none
module tcdac_analog (
  input  wire logic       clk_i,
  input  wire logic [7:0] data_i,
  input  wire logic       en_i,
  input  wire logic       oe_n_i,
  output logic      [7:0] pin_o
);
  timeunit 1ns / 1ps;
  // driven pin shows value, released pin wanders
  always_ff @(posedge clk_i) begin
    if (!oe_n_i && en_i) pin_o <= data_i;
    else pin_o <= ~pin_o;
  end
endmodule : tcdac_analog
`default_nettype wire

// ==== tb/tcdac_top_tb_top.sv ====
// self-checking bench for the converter control block
`default_nettype none
module tcdac_top_tb_top;
  import tcdac_pkg::*;
  timeunit 1ns / 1ps;
  logic clk_i = 0, nrst_i = 0, rd = 0, wr = 0, hws = 0, sws = 0;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0] wd = '0, rdat, got;
  logic [7:0] d0, d1, p0, p1;
  logic [1:0] snap;
  logic wq, e0, e1, l0, l1, o0, o1;
  int fail_count = 0, n_tests = 0, ld0 = 0, ld1 = 0;
  tcdac_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'h1), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .hw_standby_i(hws), .sw_standby_i(sws),
    .conv0_data_o(d0), .conv1_data_o(d1), .conv0_enable_o(e0),
    .conv1_enable_o(e1), .conv0_load_o(l0), .conv1_load_o(l1),
    .analog_out_pin0_oe_n_o(o0), .analog_out_pin1_oe_n_o(o1));
  tcdac_analog M0 (.clk_i(clk_i), .data_i(d0), .en_i(e0), .oe_n_i(o0),
    .pin_o(p0));
  tcdac_analog M1 (.clk_i(clk_i), .data_i(d1), .en_i(e1), .oe_n_i(o1),
    .pin_o(p1));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (l0 === 1'b1) ld0++;
    if (l1 === 1'b1) ld1++;
  end
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w,
                      input logic [7:0] d);
    int k;
    k = 0;
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk_i);
      k++;
    end while (wq !== 1'b0 && k < 40);
    if (wq !== 1'b0) begin
      fail_count++;
      $display("Error waitrequest expected 0 seen %b", wq);
    end
    got = rdat;
    wr <= 1'b0; rd <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  task automatic cmp(input string s, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    cmp("readdata", {24'h0, e}, got);
  endtask : rchk
  task automatic sby(input logic h);
    if (h) hws <= 1'b1; else sws <= 1'b1;
    repeat (8) @(posedge clk_i);
    snap = {e0, o0};
    hws <= 1'b0; sws <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : sby
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    #20000;
    fail_count++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rchk(ADDR_CHAN0_VALUE, 8'h00);
    rchk(ADDR_CHAN1_VALUE, 8'h00);
    rchk(ADDR_CONTROL, 8'h1F);
    rchk(ADDR_STANDBY_CONTROL, 8'hFE);
    rchk(22'h000010, 8'h00);
    xfer(ADDR_STANDBY_CONTROL, 1'b1, 8'h01);
    rchk(ADDR_STANDBY_CONTROL, 8'hFF);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      xfer(ADDR_CONTROL, 1'b1, {i[2:0], 5'h00});
      rchk(ADDR_CONTROL, {i[2:0], 5'h1F});
      cmp("enable0", i[1] | (i[2] & i[0]), e0);
      cmp("enable1", i[2] | (i[1] & i[0]), e1);
      cmp("pins_n", {!i[2], !i[1]}, {o1, o0});
    end
    $display("test enables done");
    xfer(ADDR_CONTROL, 1'b1, 8'h40);
    xfer(ADDR_CHAN0_VALUE, 1'b1, 8'hA5);
    xfer(ADDR_CHAN1_VALUE, 1'b1, 8'h3C);
    repeat (3) @(posedge clk_i);
    cmp("data1", 8'h3C, d1);
    cmp("load0", 1, ld0);
    cmp("load1", 0, ld1);
    cmp("pin0", 8'hA5, p0);
    rchk(ADDR_CHAN1_VALUE, 8'h3C);
    $display("test values done");
    sby(1'b0);
    cmp("sw_keep", 2'b10, snap);
    rchk(ADDR_CHAN0_VALUE, 8'hA5);
    rchk(ADDR_CONTROL, 8'h5F);
    rchk(ADDR_STANDBY_CONTROL, 8'hFF);
    xfer(ADDR_STANDBY_CONTROL, 1'b1, 8'h00);
    sby(1'b0);
    cmp("sw_off", 2'b01, snap);
    rchk(ADDR_CHAN0_VALUE, 8'h00);
    rchk(ADDR_CONTROL, 8'h1F);
    xfer(ADDR_STANDBY_CONTROL, 1'b1, 8'h01);
    xfer(ADDR_CHAN1_VALUE, 1'b1, 8'h3C);
    sby(1'b1);
    rchk(ADDR_STANDBY_CONTROL, 8'hFE);
    rchk(ADDR_CHAN1_VALUE, 8'h00);
    $display("test standby done");
    final_report();
  end
endmodule : tcdac_top_tb_top
`default_nettype wire
